// ==== src/rxaf_pkg.sv ====
// Package of register offsets, field positions, codes and timing constants for the receive frame filter.
package rxaf_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses = printed index times four)
  // ----------------------------------------------------------------------
  localparam logic [7:0]  IDX_EXT_RX_CONTROL   = 8'h17;
  localparam logic [7:0]  IDX_RETRY_CONTROL    = 8'h2c;
  localparam logic [7:0]  IDX_ACK_CONTROL      = 8'h2e;
  localparam logic [11:0] ADDR_EXT_RX_CONTROL  = {2'b00, IDX_EXT_RX_CONTROL, 2'b00};
  localparam logic [11:0] ADDR_RETRY_CONTROL   = {2'b00, IDX_RETRY_CONTROL, 2'b00};
  localparam logic [11:0] ADDR_ACK_CONTROL     = {2'b00, IDX_ACK_CONTROL, 2'b00};
  localparam logic [11:0] ADDR_NODE_PAN        = 12'h100;
  localparam logic [11:0] ADDR_NODE_SHORT      = 12'h104;
  localparam logic [11:0] ADDR_NODE_EXT_LO     = 12'h108;
  localparam logic [11:0] ADDR_NODE_EXT_HI     = 12'h10c;
  localparam logic [11:0] ADDR_STATUS          = 12'h110;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int BIT_PROMISCUOUS   = 1;
  localparam int BIT_ACK_TIME      = 2;
  localparam int BIT_RES_UPLOAD    = 4;
  localparam int BIT_RES_FILTER    = 5;
  localparam int BIT_COORD         = 3;
  localparam int BIT_ACK_DISABLE   = 4;
  localparam int BIT_VER_LO        = 6;
  localparam int BIT_SLOTTED       = 0;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  RST_EXT_RX_CONTROL = 8'h00;
  localparam logic [7:0]  RST_RETRY_CONTROL  = 8'h00;
  localparam logic [7:0]  RST_ACK_CONTROL    = 8'h40;
  localparam logic [15:0] RST_NODE_PAN       = 16'hffff;
  localparam logic [15:0] RST_NODE_SHORT     = 16'hffff;
  localparam logic [15:0] BROADCAST_ID       = 16'hffff;

  // ----------------------------------------------------------------------
  // Frame type, addressing mode and status codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] FT_BEACON  = 3'h0;
  localparam logic [2:0] FT_DATA    = 3'h1;
  localparam logic [2:0] FT_ACK     = 3'h2;
  localparam logic [2:0] FT_COMMAND = 3'h3;
  localparam logic [1:0] AM_NONE    = 2'h0;
  localparam logic [1:0] AM_SHORT   = 2'h2;
  localparam logic [1:0] AM_EXT     = 2'h3;
  localparam logic [2:0] TS_SUCCESS           = 3'h0;
  localparam logic [2:0] TS_SUCCESS_WAIT_ACK  = 3'h2;
  localparam logic [2:0] TS_INVALID           = 3'h7;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ        = 250;
  localparam int SYMBOL_NS      = 16000;
  localparam int TURN_SYMBOLS   = 12;
  localparam int SHORT_TURN_NS  = 32000;
  localparam int TRIG_DELAY_NS  = 16000;
  localparam int SYMBOL_CYC     = SYMBOL_NS * CLK_MHZ / 1000;
  localparam int TURN_CYC       = TURN_SYMBOLS * SYMBOL_CYC;
  localparam int SHORT_TURN_CYC = SHORT_TURN_NS * CLK_MHZ / 1000;
  localparam int SLOT_READY_CYC = 2 * SYMBOL_CYC;
  localparam int TRIG_DELAY_CYC = TRIG_DELAY_NS * CLK_MHZ / 1000;

  typedef enum logic [1:0] {
    RXAF_IDLE,
    RXAF_TURN,
    RXAF_WAIT_TRIG,
    RXAF_TRIG_DELAY
  } rxaf_ack_e;

endpackage

// ==== src/rxaf_filter.sv ====
// Receive frame filter and automatic acknowledgment control with an APB register slave.
//
// Functional notes
// - Coordinator-role bit at ack control bit 3.
// - Ack-disable bit 4 suppresses acknowledgments.
// - Version field 7:6 selects acknowledged versions.
// - Upload-only reserved frames bypass filter, no ack.
// - Upload plus filter: reserved frames filtered like data.
// - Reserved frame ack needs request and end-of-frame.
// - Upload clear discards reserved-type frames.
// - Ack-time clear: ack after twelve symbols.
// - Ack-time set: ack after 32 us.
// - Slotted trigger accepted two symbols after frame; with ack-time set the code accepts it only after 32 us.
// - Reject reserved types and reserved versions, with relaxations.
// - Destination PAN must match node or broadcast.
// - Destination short or extended address must match.
// - Beacon source PAN matches node unless node broadcast.
// - Source-only frames need coordinator and PAN match.
// - Reject ack frames and frames without addresses.
// - No address match for dest mode 0/1, source 0.
// - Passing frame raises address match when enabled.
// - Slotted mode holds ack until pin rising edge.
// - Slotted mode posts wait-for-ack status after two symbols; with ack-time set the code posts it after 32 us.
// - Ack starts 16 us after trigger edge.
// - Slotted enable at retry control bit 0.
// - Promiscuous mode: second-level filter, end-of-frame despite bad FCS.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps

module rxaf_filter #(
  parameter int TURN_CYCLES  = rxaf_pkg::TURN_CYC,       // Standard ack turnaround in clocks.
  parameter int SLOT_CYCLES  = rxaf_pkg::SLOT_READY_CYC  // Slotted ready delay in clocks.
) (
  input  wire logic        pclk,                // APB and block clock.
  input  wire logic        presetn,             // Asynchronous reset, active low.
  input  wire logic        psel,                // APB select.
  input  wire logic        penable,             // APB enable.
  input  wire logic        pwrite,              // APB direction.
  input  wire logic [11:0] paddr,               // APB byte address.
  input  wire logic [31:0] pwdata,              // APB write data.
  input  wire logic [3:0]  pstrb,               // APB byte strobes.
  output logic      [31:0] prdata,              // APB read data.
  output logic             pready,              // APB ready.
  output logic             pslverr,             // APB error on unmapped address.
  input  wire logic        frame_done,          // Pulse: header fields valid, last symbol received.
  input  wire logic        fcs_ok,              // Frame check sequence valid, with frame_done.
  input  wire logic [2:0]  frame_type,          // Frame type subfield.
  input  wire logic [1:0]  frame_version,       // Frame version subfield.
  input  wire logic        ack_request,         // Ack request subfield.
  input  wire logic        pan_compress,        // PAN identifier compression subfield.
  input  wire logic [1:0]  dst_mode,            // Destination addressing mode.
  input  wire logic [1:0]  src_mode,            // Source addressing mode.
  input  wire logic [15:0] dst_pan,             // Destination PAN identifier.
  input  wire logic [63:0] dst_addr,            // Destination address, short in low bits.
  input  wire logic [15:0] src_pan,             // Source PAN identifier.
  input  wire logic        address_match_en,    // Address-match interrupt enable.
  input  wire logic        sleep_transmit_pin,  // Asynchronous trigger pin.
  output logic             address_match,       // Pulse: frame passed the filter.
  output logic             end_of_frame,        // Pulse: frame delivered.
  output logic             ack_start,           // Pulse: start acknowledgment frame now.
  output logic      [2:0]  transaction_status   // Transaction status field.
);
  import rxaf_pkg::*;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0]  extended_rx_control;
  logic [7:0]  ack_control_and_seed;
  logic [7:0]  retry_control_register;
  logic [15:0] node_pan;
  logic [15:0] node_short;
  logic [63:0] node_ext;

  logic promiscuous_enable, ack_time_select, reserved_type_upload, reserved_type_filter;
  logic coordinator_role, ack_disable, slotted_en;
  logic [1:0] version_ack_field;

  assign promiscuous_enable   = extended_rx_control[BIT_PROMISCUOUS];
  assign ack_time_select      = extended_rx_control[BIT_ACK_TIME];
  assign reserved_type_upload = extended_rx_control[BIT_RES_UPLOAD];
  assign reserved_type_filter = extended_rx_control[BIT_RES_FILTER];
  assign coordinator_role     = ack_control_and_seed[BIT_COORD];
  assign ack_disable          = ack_control_and_seed[BIT_ACK_DISABLE];
  assign version_ack_field    = ack_control_and_seed[BIT_VER_LO +: 2];
  assign slotted_en           = retry_control_register[BIT_SLOTTED];

  // Byte-lane merge for an 8-bit wide register slice.
  function automatic logic [7:0] lane(input logic [7:0] old, input logic [7:0] nw, input logic en);
    lane = en ? nw : old;
  endfunction

  // ----------------------------------------------------------------------
  // APB slave: zero wait states, unmapped addresses answer with an error
  // ----------------------------------------------------------------------
  logic apb_wr, mapped;
  assign pready  = 1'b1;
  assign apb_wr  = psel & penable & pwrite;
  always_comb begin
    mapped = 1'b1;
    prdata = 32'h0000_0000;
    unique case (paddr)
      ADDR_EXT_RX_CONTROL: prdata = {24'h000000, extended_rx_control};
      ADDR_ACK_CONTROL:    prdata = {24'h000000, ack_control_and_seed};
      ADDR_RETRY_CONTROL:  prdata = {24'h000000, retry_control_register};
      ADDR_NODE_PAN:       prdata = {16'h0000, node_pan};
      ADDR_NODE_SHORT:     prdata = {16'h0000, node_short};
      ADDR_NODE_EXT_LO:    prdata = node_ext[31:0];
      ADDR_NODE_EXT_HI:    prdata = node_ext[63:32];
      ADDR_STATUS:         prdata = {29'h0000_0000, transaction_status};
      default:             mapped = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~mapped;

  // Register writes take effect only at the access phase edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      extended_rx_control    <= RST_EXT_RX_CONTROL;
      ack_control_and_seed   <= RST_ACK_CONTROL;
      retry_control_register <= RST_RETRY_CONTROL;
      node_pan               <= RST_NODE_PAN;
      node_short             <= RST_NODE_SHORT;
      node_ext               <= 64'h0000_0000_0000_0000;
    end else if (apb_wr) begin
      unique case (paddr)
        ADDR_EXT_RX_CONTROL: extended_rx_control <= lane(extended_rx_control, pwdata[7:0], pstrb[0]);
        ADDR_ACK_CONTROL:    ack_control_and_seed <= lane(ack_control_and_seed, pwdata[7:0], pstrb[0]);
        ADDR_RETRY_CONTROL:  retry_control_register <= lane(retry_control_register, pwdata[7:0], pstrb[0]);
        ADDR_NODE_PAN: begin
          node_pan[7:0]  <= lane(node_pan[7:0], pwdata[7:0], pstrb[0]);
          node_pan[15:8] <= lane(node_pan[15:8], pwdata[15:8], pstrb[1]);
        end
        ADDR_NODE_SHORT: begin
          node_short[7:0]  <= lane(node_short[7:0], pwdata[7:0], pstrb[0]);
          node_short[15:8] <= lane(node_short[15:8], pwdata[15:8], pstrb[1]);
        end
        ADDR_NODE_EXT_LO: begin
          for (int i = 0; i < 4; i++) begin
            node_ext[8*i +: 8] <= lane(node_ext[8*i +: 8], pwdata[8*i +: 8], pstrb[i]);
          end
        end
        ADDR_NODE_EXT_HI: begin
          for (int i = 0; i < 4; i++) begin
            node_ext[32+8*i +: 8] <= lane(node_ext[32+8*i +: 8], pwdata[8*i +: 8], pstrb[i]);
          end
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Filter decision, purely combinational on the frame_done cycle
  // ----------------------------------------------------------------------
  logic is_reserved, res_bypass, version_ok, addr_pass, match_modes_ok, deliver, amatch, want_ack;
  logic [15:0] eff_src_pan;

  function automatic logic ver_acked(input logic [1:0] mode, input logic [1:0] ver);
    unique case (mode)
      2'b00:   ver_acked = (ver == 2'd0);
      2'b01:   ver_acked = (ver <= 2'd1);
      2'b10:   ver_acked = (ver <= 2'd2);
      default: ver_acked = 1'b1;
    endcase
  endfunction

  always_comb begin
    is_reserved = frame_type > FT_COMMAND;
    // upload without filter bypasses address checks
    res_bypass  = is_reserved & reserved_type_upload & ~reserved_type_filter;
    // reserved versions pass only when the version field allows them
    version_ok  = ver_acked(version_ack_field, frame_version) | (frame_version != 2'd3);
    eff_src_pan = pan_compress ? dst_pan : src_pan;
    addr_pass   = 1'b1;
    if (dst_mode != AM_NONE && dst_pan != node_pan && dst_pan != BROADCAST_ID)
      addr_pass = 1'b0;
    if (dst_mode == AM_SHORT && dst_addr[15:0] != node_short && dst_addr[15:0] != BROADCAST_ID)
      addr_pass = 1'b0;
    if (dst_mode == AM_EXT && dst_addr != node_ext)
      addr_pass = 1'b0;
    if (frame_type == FT_BEACON && node_pan != BROADCAST_ID && src_pan != node_pan)
      addr_pass = 1'b0;
    // source-only data, command or filtered reserved frames
    if ((frame_type == FT_DATA || frame_type == FT_COMMAND || is_reserved) && dst_mode == AM_NONE &&
        src_mode != AM_NONE && !(coordinator_role && eff_src_pan == node_pan))
      addr_pass = 1'b0;
    // no ack frames, at least one address field
    if (frame_type == FT_ACK || (dst_mode == AM_NONE && src_mode == AM_NONE))
      addr_pass = 1'b0;
    if (is_reserved && !reserved_type_upload)
      addr_pass = 1'b0;
    if (!version_ok)
      addr_pass = 1'b0;
    // no match for dest mode 0/1 with no source
    match_modes_ok = !((dst_mode == AM_NONE || dst_mode == 2'd1) && src_mode == AM_NONE);
    // match announced for filtered frames when enabled
    amatch = addr_pass & match_modes_ok & ~res_bypass & ~(is_reserved & ~reserved_type_upload);
    // promiscuous delivers every frame except reserved types with upload clear, even with a bad FCS
    if (promiscuous_enable)
      deliver = ~(is_reserved & ~reserved_type_upload);
    else if (res_bypass)
      deliver = fcs_ok;
    else
      deliver = addr_pass & fcs_ok;
    // ack needs request, delivery and an accepted version
    want_ack = deliver & fcs_ok & ack_request & ~ack_disable & ~res_bypass & addr_pass &
               ver_acked(version_ack_field, frame_version);
  end

  // one-cycle event pulses registered from the single decision
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      address_match <= 1'b0;
      end_of_frame  <= 1'b0;
    end else begin
      address_match <= frame_done & amatch & address_match_en;
      end_of_frame  <= frame_done & deliver;
    end
  end

  // ----------------------------------------------------------------------
  // Trigger pin synchroniser and edge detector
  // ----------------------------------------------------------------------
  logic pin_s1, pin_s2, pin_s3, pin_rise;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
    end else begin
      pin_s1 <= sleep_transmit_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end
  assign pin_rise = pin_s2 & ~pin_s3;

  // ----------------------------------------------------------------------
  // Acknowledgment timing. The counter is wide enough for the standard
  // turnaround; a trigger edge before the slotted ready point is ignored.
  // ----------------------------------------------------------------------
  rxaf_ack_e   ack_state;
  logic [15:0] ack_cnt;
  logic [15:0] turn_target;

  always_comb begin
    if (ack_time_select)
      turn_target = 16'(SHORT_TURN_CYC);
    else if (slotted_en)
      turn_target = 16'(SLOT_CYCLES);
    else
      turn_target = 16'(TURN_CYCLES);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_state <= RXAF_IDLE;
      ack_cnt   <= 16'h0000;
      ack_start <= 1'b0;
    end else begin
      ack_start <= 1'b0;
      unique case (ack_state)
        RXAF_IDLE: begin
          if (frame_done && want_ack) begin
            ack_state <= RXAF_TURN;
            ack_cnt   <= 16'h0001;
          end
        end
        RXAF_TURN: begin
          ack_cnt <= ack_cnt + 16'h0001;
          if (ack_cnt >= turn_target) begin
            ack_cnt <= 16'h0000;
            // slotted mode waits for the pin
            if (slotted_en) begin
              ack_state <= RXAF_WAIT_TRIG;
            end else begin
              ack_state <= RXAF_IDLE;
              ack_start <= 1'b1;
            end
          end
        end
        RXAF_WAIT_TRIG: begin
          if (pin_rise) begin
            ack_state <= RXAF_TRIG_DELAY;
            ack_cnt   <= 16'h0001;
          end
        end
        RXAF_TRIG_DELAY: begin
          ack_cnt <= ack_cnt + 16'h0001;
          // ack starts 16 us after the edge
          if (ack_cnt >= 16'(TRIG_DELAY_CYC)) begin
            ack_state <= RXAF_IDLE;
            ack_start <= 1'b1;
            ack_cnt   <= 16'h0000;
          end
        end
      endcase
    end
  end

  // Frame type of the frame being acknowledged. Only the frame that starts an
  // ack is kept, so a later frame during the wait cannot change the status.
  logic [2:0] frame_type_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      frame_type_q <= FT_BEACON;
    else if (ack_state == RXAF_IDLE && frame_done && want_ack)
      frame_type_q <= frame_type;
  end

  // status shows wait-for-ack once slotted ready point is reached for a data or command frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transaction_status <= TS_INVALID;
    end else if (ack_state == RXAF_TURN && slotted_en && ack_cnt >= turn_target &&
                 (frame_type_q == FT_DATA || frame_type_q == FT_COMMAND)) begin
      transaction_status <= TS_SUCCESS_WAIT_ACK;
    end else if (ack_start) begin
      transaction_status <= TS_SUCCESS;
    end
  end

endmodule

// ==== verif/rxaf_filter_props.sv ====
// Concurrent checks on the frame filter event outputs and the APB answer.
`timescale 1ns/1ps

module rxaf_filter_props (
  input wire logic       pclk,              // Block clock.
  input wire logic       presetn,           // Reset, active low.
  input wire logic       psel,              // APB select.
  input wire logic       penable,           // APB enable.
  input wire logic       pready,            // APB ready.
  input wire logic       pslverr,           // APB error.
  input wire logic       frame_done,        // Frame end strobe.
  input wire logic [2:0] frame_type,        // Frame type.
  input wire logic [1:0] dst_mode,          // Destination mode.
  input wire logic [1:0] src_mode,          // Source mode.
  input wire logic       address_match_en,  // Match event enable.
  input wire logic       address_match,     // Match event.
  input wire logic       end_of_frame       // Delivery event.
);
  // -------------------------------------------------------------------
  // Properties
  // -------------------------------------------------------------------
  // All checks share one clock; reset cancels any check in flight.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_EOF_PULSE: assert property (end_of_frame |=> !end_of_frame)
    else $error("end_of_frame longer than one cycle");
  AST_AM_PULSE: assert property (address_match |=> !address_match)
    else $error("address_match longer than one cycle");
  AST_EOF_CAUSE: assert property (end_of_frame |-> $past(frame_done))
    else $error("end_of_frame without a frame one cycle before");
  AST_AM_CAUSE: assert property (address_match |-> $past(frame_done) && $past(address_match_en))
    else $error("address_match without an enabled frame");
  AST_NO_AM_MODES: assert property (frame_done && dst_mode <= 2'h1 && src_mode == 2'h0 |=> !address_match)
    else $error("address_match for a frame without announced addressing");
  AST_NO_AM_ACK: assert property (frame_done && frame_type == 3'h2 |=> !address_match)
    else $error("address_match for an acknowledgment frame");
  AST_READY: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  AST_ERR_PHASE: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
endmodule

bind rxaf_filter rxaf_filter_props u_props (.*);

// ==== verif/rxaf_host_model.sv ====
// Host model that drives the sleep/transmit trigger pin.
`timescale 1ns/1ps

module rxaf_host_model (
  input  wire logic pclk,               // Host clock, same as block clock.
  input  wire logic presetn,            // Reset, active low.
  input  wire logic go,                 // Bench command to raise the pin.
  output logic      sleep_transmit_pin  // Trigger pin to the block.
);
  // bench times trigger, host re-times it
  // The bench raises go at the slot time; the host only re-times it to its own edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_transmit_pin <= 1'b0;
    end else begin
      sleep_transmit_pin <= go;
    end
  end
endmodule

// ==== verif/rx_auto_ack_frame_filter_tb_top.sv ====
// Self-checking bench for the receive frame filter and acknowledgment timing.
`timescale 1ns/1ps

module rx_auto_ack_frame_filter_tb_top;
  import rxaf_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, frame_done, fcs_ok, ack_request, am_en, go;
  logic        pready, pslverr, address_match, end_of_frame, ack_start, sleep_transmit_pin, err, am, eof, ack;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  frame_type, transaction_status;
  logic [1:0]  frame_version, dst_mode, src_mode;
  logic [15:0] dst_pan, src_pan;
  logic [63:0] dst_addr;
  int          bad_count, tests_run, n;

  // Shortened turnaround counts keep the run brief.
  rxaf_filter #(.TURN_CYCLES(20), .SLOT_CYCLES(8)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_done(frame_done), .fcs_ok(fcs_ok), .frame_type(frame_type), .frame_version(frame_version),
    .ack_request(ack_request), .pan_compress(1'b0), .dst_mode(dst_mode), .src_mode(src_mode),
    .dst_pan(dst_pan), .dst_addr(dst_addr), .src_pan(src_pan), .address_match_en(am_en),
    .sleep_transmit_pin(sleep_transmit_pin), .address_match(address_match), .end_of_frame(end_of_frame),
    .ack_start(ack_start), .transaction_status(transaction_status));

  rxaf_host_model u_host (.pclk(pclk), .presetn(presetn), .go(go), .sleep_transmit_pin(sleep_transmit_pin));

  // -------------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------------
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is seen at an edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
    if (i == 50) begin
      bad_count++;
      close_out();
    end
  endtask

  // One received frame, then a bounded watch for the acknowledgment start.
  task automatic fr(input logic [2:0] t, logic [1:0] v, logic r, logic [1:0] dm, logic [1:0] sm,
                    logic [15:0] dp, logic [63:0] da, logic [15:0] sp, int lim);
    frame_type <= t; frame_version <= v; ack_request <= r; dst_mode <= dm; src_mode <= sm;
    dst_pan <= dp; dst_addr <= da; src_pan <= sp; frame_done <= 1'b1;
    ack = 1'b0;
    n = 0;
    for (int i = 1; i <= lim; i++) begin
      @(posedge pclk);
      if (i == 1) frame_done <= 1'b0;
      #1;
      if (i == 1) begin
        am = address_match;
        eof = end_of_frame;
      end
      if (ack_start === 1'b1) begin
        ack = 1'b1;
        n = i;
        break;
      end
    end
    @(posedge pclk);
  endtask

  task automatic tc(input logic [2:0] t, logic [1:0] v, logic r, logic [1:0] dm, logic [1:0] sm,
                    logic [15:0] dp, logic [63:0] da, logic [15:0] sp, logic [2:0] ex);
    fr(t, v, r, dm, sm, dp, da, sp, 30);
    chk({29'h0, am, eof, ack}, {29'h0, ex});
  endtask

  // -------------------------------------------------------------------
  // Stimulus
  // -------------------------------------------------------------------
  initial begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end

  initial begin
    {presetn, psel, penable, pwrite, frame_done, ack_request, go} = '0;
    {fcs_ok, am_en} = 2'b11;
    {paddr, pwdata, frame_type, frame_version, dst_mode, src_mode, dst_pan, src_pan, dst_addr} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(transaction_status, TS_INVALID);
    apb(0, ADDR_ACK_CONTROL, 0); chk(rd, RST_ACK_CONTROL);
    apb(0, ADDR_EXT_RX_CONTROL, 0); chk(rd, 0);
    apb(0, ADDR_RETRY_CONTROL, 0); chk(rd, 0);
    apb(0, 12'h004, 0); chk(rd, 0);
    chk({31'h0, err}, 1);
    apb(1, ADDR_NODE_PAN, 32'h1234); apb(1, ADDR_NODE_SHORT, 32'h55);
    apb(1, ADDR_NODE_EXT_LO, 32'h89abcdef); apb(1, ADDR_NODE_EXT_HI, 32'h01234567);
    tc(FT_DATA, 1, 1, AM_SHORT, AM_SHORT, 16'h1234, 64'h55, 16'h1234, 3'b111);
    chk(n >= 21 && n <= 24, 1);
    tc(FT_DATA, 1, 1, AM_SHORT, AM_SHORT, 16'h4321, 64'h55, 16'h1234, 3'b000);
    tc(FT_DATA, 1, 0, AM_SHORT, AM_SHORT, 16'hffff, 64'hffff, 16'h1234, 3'b110);
    tc(FT_DATA, 1, 1, AM_SHORT, AM_SHORT, 16'h1234, 64'h56, 16'h1234, 3'b000);
    tc(FT_DATA, 1, 1, AM_EXT, AM_SHORT, 16'h1234, 64'h0123456789abcdef, 16'h1234, 3'b111);
    tc(FT_BEACON, 0, 0, AM_NONE, AM_SHORT, 0, 0, 16'h4321, 3'b000);
    tc(FT_BEACON, 0, 0, AM_NONE, AM_SHORT, 0, 0, 16'h1234, 3'b110);
    tc(FT_DATA, 1, 1, AM_NONE, AM_SHORT, 0, 0, 16'h1234, 3'b000);
    tc(FT_ACK, 1, 0, AM_SHORT, AM_SHORT, 16'h1234, 64'h55, 16'h1234, 3'b000);
    tc(FT_DATA, 1, 1, AM_NONE, AM_NONE, 0, 0, 0, 3'b000);
    tc(FT_DATA, 2, 1, AM_SHORT, AM_SHORT, 16'h1234, 64'h55, 16'h1234, 3'b110);
    tc(FT_DATA, 3, 1, AM_SHORT, AM_SHORT, 16'h1234, 64'h55, 16'h1234, 3'b000);
    apb(1, ADDR_ACK_CONTROL, 32'h88);
    tc(FT_DATA, 2, 1, AM_SHORT, AM_SHORT, 16'h1234, 64'h55, 16'h1234, 3'b111);
    tc(FT_DATA, 1, 1, AM_NONE, AM_SHORT, 0, 0, 16'h1234, 3'b111);
    apb(1, ADDR_ACK_CONTROL, 32'h00);
    tc(FT_DATA, 1, 1, AM_SHORT, AM_SHORT, 16'h1234, 64'h55, 16'h1234, 3'b110);
    apb(1, ADDR_ACK_CONTROL, 32'hd0);
    tc(FT_DATA, 3, 1, AM_SHORT, AM_SHORT, 16'h1234, 64'h55, 16'h1234, 3'b110);
    apb(1, ADDR_ACK_CONTROL, 32'h40);
    tc(3'h5, 1, 1, AM_SHORT, AM_SHORT, 16'h1234, 64'h55, 16'h1234, 3'b000);
    apb(1, ADDR_EXT_RX_CONTROL, 32'h10);
    tc(3'h5, 1, 1, AM_SHORT, AM_SHORT, 16'h4321, 64'h55, 16'h1234, 3'b010);
    apb(1, ADDR_EXT_RX_CONTROL, 32'h30);
    tc(3'h5, 1, 1, AM_SHORT, AM_SHORT, 16'h1234, 64'h55, 16'h1234, 3'b111);
    tc(3'h5, 1, 1, AM_SHORT, AM_SHORT, 16'h4321, 64'h55, 16'h1234, 3'b000);
    am_en <= 1'b0;
    tc(FT_DATA, 1, 1, AM_SHORT, AM_SHORT, 16'h1234, 64'h55, 16'h1234, 3'b011);
    am_en <= 1'b1;
    apb(1, ADDR_EXT_RX_CONTROL, 32'h02);
    fcs_ok <= 1'b0;
    fr(FT_DATA, 1, 1, AM_SHORT, AM_SHORT, 16'h1234, 64'h55, 16'h1234, 30);
    chk({eof, ack}, 2'b10);
    fcs_ok <= 1'b1;
    apb(1, ADDR_EXT_RX_CONTROL, 32'h04);
    fr(FT_DATA, 1, 1, AM_SHORT, AM_SHORT, 16'h1234, 64'h55, 16'h1234, 8100);
    chk(n >= 8001 && n <= 8004, 1);
    // Slotted: an early trigger is ignored, a trigger after the ready status starts the ack.
    apb(1, ADDR_EXT_RX_CONTROL, 32'h00); apb(1, ADDR_RETRY_CONTROL, 32'h01);
    fr(FT_DATA, 1, 1, AM_SHORT, AM_SHORT, 16'h1234, 64'h55, 16'h1234, 2);
    go <= 1'b1;
    repeat (3) @(posedge pclk);
    go <= 1'b0;
    fr(FT_BEACON, 0, 0, AM_NONE, AM_NONE, 0, 0, 0, 40);
    chk(ack, 0);
    chk(transaction_status, TS_SUCCESS_WAIT_ACK);
    go <= 1'b1;
    for (n = 1; n < 4100; n++) begin
      @(posedge pclk);
      #1;
      if (ack_start === 1'b1) break;
    end
    go <= 1'b0;
    chk(n >= 4001 && n <= 4008, 1);
    close_out();
  end
endmodule
